// File: inc/iscp_pkg.sv
// Purpose: constants for the fast and high-speed scl period registers
// Assumes: 32-bit register access, byte-addressed offsets
// Notes: count field is 14 bits, upper bits read as zero
package iscp_pkg;
  localparam int unsigned ISCP_ADDR_W = 8;
  localparam int unsigned ISCP_DATA_W = 32;
  localparam int unsigned ISCP_CNT_W = 14;
  localparam logic [ISCP_ADDR_W-1:0] ISCP_FAST_LOW_OFS = 8'h20;
  localparam logic [ISCP_ADDR_W-1:0] ISCP_HS_HIGH_OFS = 8'h24;
  localparam logic [ISCP_CNT_W-1:0] ISCP_FAST_LOW_RST = 14'h0082;
  localparam logic [ISCP_CNT_W-1:0] ISCP_HS_HIGH_RST = 14'h0006;
  localparam logic [ISCP_CNT_W-1:0] ISCP_FAST_LOW_MIN = 14'h0008;
  localparam logic [ISCP_CNT_W-1:0] ISCP_HS_HIGH_MIN = 14'h0006;
  localparam logic [ISCP_DATA_W-1:0] ISCP_UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {
    ISCP_SPEED_STD = 2'h0,
    ISCP_SPEED_FAST = 2'h1,
    ISCP_SPEED_HIGH = 2'h2
  } iscp_speed_t;
endpackage

// File: verilog/iscp_period_regs.sv
// Purpose: scl period count registers for fast/fast-plus and high-speed modes
// Assumes: single clock, register write/read strobes synchronous to clock
// Notes: byte enables model a 16-bit bus writing low byte then high byte
//
// Overview of operation
// - fast count sets scl low phase
// - fast count also for master code, start
// - high-speed count sets scl high phase
// - software programs both before any transfer
// - writes accepted only while interface disabled
// - fast count below 8 stored as 8
// - high-speed count below 6 stored as 6
// - fast count resets to 0x82, bits 13:0
// - high-speed count resets to 0x6, bits 13:0
`timescale 1ns/10ps
module iscp_period_regs
  import iscp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic interface_enable,
  input wire iscp_pkg::iscp_speed_t speed_mode,
  input wire logic send_special_code,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [iscp_pkg::ISCP_ADDR_W-1:0] addr,
  input wire logic [iscp_pkg::ISCP_DATA_W-1:0] wdata,
  input wire logic [3:0] byte_en,
  output logic [iscp_pkg::ISCP_DATA_W-1:0] rdata,
  output logic [iscp_pkg::ISCP_CNT_W-1:0] fast_scl_low_count,
  output logic [iscp_pkg::ISCP_CNT_W-1:0] highspeed_scl_high_count,
  output logic [iscp_pkg::ISCP_CNT_W-1:0] scl_low_phase_count,
  output logic [iscp_pkg::ISCP_CNT_W-1:0] scl_high_phase_count,
  output logic use_fast_low,
  output logic use_hs_high
);
  import iscp_pkg::*;

  logic [ISCP_CNT_W-1:0] fast_low_reg;
  logic [ISCP_CNT_W-1:0] fast_low_next;
  logic [ISCP_CNT_W-1:0] hs_high_reg;
  logic [ISCP_CNT_W-1:0] hs_high_next;
  logic [ISCP_DATA_W-1:0] rdata_reg;
  logic [ISCP_DATA_W-1:0] rdata_next;
  logic [ISCP_CNT_W-1:0] fast_merged;
  logic [ISCP_CNT_W-1:0] hs_merged;
  logic wr_ok;

  // elaboration checks: the logic serves a 9..16 bit count on a bus of at least 16 bits
  if (ISCP_CNT_W <= 8 || ISCP_CNT_W > 16) begin : g_bad_cnt_w
    $error("count width must lie between 9 and 16 bits");
  end
  if (ISCP_DATA_W < 16) begin : g_bad_data_w
    $error("register data width must be at least 16 bits");
  end
  if (ISCP_FAST_LOW_OFS == ISCP_HS_HIGH_OFS) begin : g_bad_ofs
    $error("the two count registers need distinct offsets");
  end
  if (ISCP_FAST_LOW_RST < ISCP_FAST_LOW_MIN || ISCP_HS_HIGH_RST < ISCP_HS_HIGH_MIN) begin : g_bad_rst
    $error("reset counts must not lie below their minimum");
  end

  // byte merge keeps unwritten bytes, so a 16-bit bus can update one byte at a time
  function automatic logic [ISCP_CNT_W-1:0] merge_bytes(
    input logic [ISCP_CNT_W-1:0] old_val,
    input logic [ISCP_DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [ISCP_CNT_W-1:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[ISCP_CNT_W-1:8] = wd[ISCP_CNT_W-1:8];
    end
    return res;
  endfunction

  assign wr_ok = wr_en && !interface_enable;
  assign fast_merged = merge_bytes(fast_low_reg, wdata, byte_en);
  assign hs_merged = merge_bytes(hs_high_reg, wdata, byte_en);

  always_comb begin
    fast_low_next = fast_low_reg;
    if (wr_ok && addr == ISCP_FAST_LOW_OFS) begin
      if (fast_merged < ISCP_FAST_LOW_MIN) begin
        fast_low_next = ISCP_FAST_LOW_MIN;
      end else begin
        fast_low_next = fast_merged;
      end
    end
  end

  always_comb begin
    hs_high_next = hs_high_reg;
    if (wr_ok && addr == ISCP_HS_HIGH_OFS) begin
      if (hs_merged < ISCP_HS_HIGH_MIN) begin
        hs_high_next = ISCP_HS_HIGH_MIN;
      end else begin
        hs_high_next = hs_merged;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fast_low_reg <= ISCP_FAST_LOW_RST;
    end else begin
      fast_low_reg <= fast_low_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_high_reg <= ISCP_HS_HIGH_RST;
    end else begin
      hs_high_reg <= hs_high_next;
    end
  end

  // read data: count in low bits, reserved bits zero
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      rdata_next = ISCP_UNMAPPED_RD;
      if (addr == ISCP_FAST_LOW_OFS) begin
        rdata_next[ISCP_CNT_W-1:0] = fast_low_reg;
      end else if (addr == ISCP_HS_HIGH_OFS) begin
        rdata_next[ISCP_CNT_W-1:0] = hs_high_reg;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ISCP_UNMAPPED_RD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign fast_scl_low_count = fast_low_reg;
  assign highspeed_scl_high_count = hs_high_reg;

  // count selection for the scl waveform engine
  always_comb begin
    use_fast_low = 1'b0;
    use_hs_high = 1'b0;
    scl_low_phase_count = fast_low_reg;
    scl_high_phase_count = hs_high_reg;
    if (speed_mode == ISCP_SPEED_FAST) begin
      use_fast_low = 1'b1;
    end else if (speed_mode == ISCP_SPEED_HIGH) begin
      use_hs_high = 1'b1;
      use_fast_low = send_special_code;
    end
  end
endmodule

// File: verif/iscp_partner.sv
// Purpose: far side user of the active scl phase count
// Assumes: counts programmed first
// Notes: zero when no count in use
`timescale 1ns/10ps
module iscp_partner (input wire logic [13:0] lo, hi, input wire logic uf, uh,
  output logic [13:0] ph);
  assign ph = uf ? lo : uh ? hi : 14'h0;
endmodule

// File: verif/iscp_props.sv
// Purpose: port checker
// Assumes: one clock
// Notes: bound below
`timescale 1ns/10ps
module iscp_props import iscp_pkg::*; (
  input wire logic clock, rst_n, interface_enable, send_special_code, rd_en,
  input wire iscp_speed_t speed_mode,
  input wire logic [7:0] addr,
  input wire logic [31:0] rdata,
  input wire logic [13:0] fast_scl_low_count, highspeed_scl_high_count,
  input wire logic [13:0] scl_low_phase_count, scl_high_phase_count,
  input wire logic use_fast_low
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_lo_phase: assert property (scl_low_phase_count == fast_scl_low_count)
    else $error("lo phase");
  a_hi_phase: assert property (scl_high_phase_count == highspeed_scl_high_count)
    else $error("hi phase");
  a_fast_use: assert property (use_fast_low == (speed_mode == ISCP_SPEED_FAST ||
    speed_mode == ISCP_SPEED_HIGH && send_special_code)) else $error("fast use");
  a_wr_lock: assert property (interface_enable |=> $stable(fast_scl_low_count)
    && $stable(highspeed_scl_high_count)) else $error("locked");
  a_fast_min: assert property (fast_scl_low_count >= ISCP_FAST_LOW_MIN)
    else $error("fast min");
  a_hs_min: assert property (highspeed_scl_high_count >= ISCP_HS_HIGH_MIN)
    else $error("hs min");
  a_rst_val: assert property ($rose(rst_n) |-> fast_scl_low_count == ISCP_FAST_LOW_RST
    && highspeed_scl_high_count == ISCP_HS_HIGH_RST) else $error("reset");
  a_rd_back: assert property (rd_en && addr == ISCP_FAST_LOW_OFS |=>
    rdata == {18'h0, $past(fast_scl_low_count)}) else $error("read");
endmodule
bind iscp_period_regs iscp_props i_props(.*);

// File: verif/tb_iscp_period_regs.sv
// Purpose: bench with integer model
// Assumes: inputs driven at falling edge
// Notes: m holds expected counts
`timescale 1ns/10ps
module tb_iscp_period_regs;
  import iscp_pkg::*;
  logic clock = 0, rst_n = 0, en = 0, ss = 0, wr = 0, rd = 0;
  iscp_speed_t sm = ISCP_SPEED_STD;
  logic [7:0] ad = 0;
  logic [31:0] wd = 0, rdata;
  logic [3:0] be = 4'hf;
  logic [13:0] lo, hi, ph, fo, ho;
  logic uf, uh;
  int error_cnt = 0, check_count = 0, j, k, t, e;
  int m[2] = '{ISCP_FAST_LOW_RST, ISCP_HS_HIGH_RST};
  always #12.5 clock = ~clock;
  iscp_period_regs i_dut(.clock, .rst_n, .interface_enable(en), .speed_mode(sm),
    .send_special_code(ss), .wr_en(wr), .rd_en(rd), .addr(ad), .wdata(wd), .byte_en(be),
    .rdata, .fast_scl_low_count(fo), .highspeed_scl_high_count(ho), .scl_low_phase_count(lo),
    .scl_high_phase_count(hi), .use_fast_low(uf), .use_hs_high(uh));
  iscp_partner i_far(.lo, .hi, .uf, .uh, .ph);
  task chk(string n, logic [31:0] e, logic [31:0] v);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, v);
    end
  endtask
  task op(logic w, int a, int d);
    @(negedge clock);
    wr = w; rd = !w; ad = 8'(a); wd = 32'(d);
    if (w && !en && a[7:3] == 4) begin
      k = a[2]; t = m[k];
      if (be[0]) t[7:0] = d[7:0];
      if (be[1]) t[13:8] = d[13:8];
      e = k ? ISCP_HS_HIGH_MIN : ISCP_FAST_LOW_MIN;
      m[k] = t < e ? e : t;
    end
    @(negedge clock);
    wr = 0; rd = 0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(39023));
    repeat (16) @(negedge clock);
    rst_n = 1;
    for (int a = 0; a < 3; a++) begin
      op(0, 32 + 4 * a, 0);
      chk("reset", a < 2 ? m[a] : 0, rdata);
    end
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      en = i < 50 ? $urandom_range(0, 1) : 0;
      be = i < 50 ? 4'hf : 4'h1 << (i % 2);
      j = $urandom_range(0, 1);
      op(1, 32 + 4 * j, $urandom_range(0, 12) << 7 * $urandom_range(0, 1));
      op(0, 32 + 4 * j, 0);
      chk("count", m[j], rdata);
      chk("fast_out", m[0], fo);
      chk("hs_out", m[1], ho);
      sm = iscp_speed_t'(i % 3); ss = i[2];
      #1;
      chk("phase", i % 3 == 1 || i % 3 == 2 && ss ? m[0] : i % 3 == 2 ? m[1] : 0, ph);
    end
    $display("test random done");
    close_out;
  end
  initial begin
    repeat (9000) @(posedge clock);
    error_cnt++;
    close_out;
  end
endmodule
